// >>> e3tt_pkg.sv
// Constants, field layouts and carrier types of the E3 trail trace controller
package e3tt_pkg;

   // ****************************************************************
   // Identifier geometry
   // ****************************************************************
   localparam int         E3TT_ID_BYTES = 16;
   localparam logic [3:0] E3TT_LAST_POS = 4'hf;

   // ****************************************************************
   // Register map (8-bit address, 8-bit data)
   // ****************************************************************
   localparam logic [7:0] E3TT_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] E3TT_ADDR_STATUS = 8'h01;
   localparam logic [3:0] E3TT_PAGE_TX     = 4'h1;
   localparam logic [3:0] E3TT_PAGE_EXP    = 4'h2;
   localparam logic [3:0] E3TT_PAGE_CUR    = 4'h3;
   localparam logic [3:0] E3TT_PAGE_RX     = 4'h4;

   // Control register fields
   localparam int         E3TT_CTRL_TX_REORDER = 0;
   localparam int         E3TT_CTRL_TX_ALIGN   = 1;
   localparam int         E3TT_CTRL_TX_INVERT  = 2;
   localparam int         E3TT_CTRL_TX_IDLE    = 3;
   localparam int         E3TT_CTRL_RX_INVERT  = 4;
   localparam int         E3TT_CTRL_RX_ALIGN   = 5;
   localparam int         E3TT_CTRL_RX_REORDER = 6;
   localparam int         E3TT_CTRL_CMP_EN     = 7;
   localparam logic [7:0] E3TT_CTRL_RESET      = 8'h00;

   // Status register fields
   localparam int         E3TT_STAT_CHANGE   = 0;
   localparam int         E3TT_STAT_IDLE     = 1;
   localparam int         E3TT_STAT_UNSTABLE = 2;
   localparam int         E3TT_STAT_MISMATCH = 3;
   localparam int         E3TT_STAT_LOCKED   = 4;
   localparam int         E3TT_STAT_RXVALID  = 5;

   // ****************************************************************
   // Persistence counts (identifiers)
   // ****************************************************************
   localparam logic [3:0] E3TT_CHANGE_REPEAT   = 4'h5;
   localparam logic [3:0] E3TT_IDLE_REPEAT     = 4'h5;
   localparam logic [3:0] E3TT_CLEAR_REPEAT    = 4'h5;
   localparam logic [3:0] E3TT_UNSTABLE_REPEAT = 4'h8;

   // Alarm forcing value and payload mask in line order
   localparam logic [7:0] E3TT_ALL_ONES     = 8'hff;
   localparam logic [7:0] E3TT_PAYLOAD_MASK = 8'h7f;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef logic [E3TT_ID_BYTES-1:0][7:0] e3tt_id_t;

   typedef enum logic {
      E3TT_HUNT = 1'b0,
      E3TT_SYNC = 1'b1
   } e3tt_align_t;

   // Line-side inputs as sampled together
   typedef struct packed {
      logic       lclk;
      logic       strobe;
      logic [2:0] alarm;
      logic       datapath_reset_n_n;
      logic [7:0] data;
   } e3tt_line_t;

   // Receive persistence tracking
   typedef struct packed {
      logic [3:0] same_cnt;
      logic [3:0] zero_cnt;
      logic [3:0] nz_cnt;
      logic [3:0] unst_cnt;
      logic       acc_same;
      logic       acc_rx;
      logic       acc_zero;
   } e3tt_track_t;

   typedef struct packed {
      e3tt_line_t  sync1;
      e3tt_line_t  sync2;
      logic        lclk_prev;
      logic [7:0]  ctrl;
      logic [7:0]  rdata;
      e3tt_id_t    tx_id;
      logic [3:0]  tx_pos;
      logic [7:0]  tx_byte;
      e3tt_id_t    cur_id;
      e3tt_id_t    rx_id;
      e3tt_id_t    exp_id;
      logic        rx_valid;
      e3tt_align_t astate;
      logic [3:0]  wr_pos;
      e3tt_track_t trk;
      logic        change;
      logic        idle;
      logic        unstable;
      logic        mismatch;
   } e3tt_state_t;

endpackage

// >>> e3tt_trace_ctrl.sv
// E3 trail trace controller: transmit insertion, receive extraction and checks
`timescale 1ns/100ps

// Functional notes
// - Sixteen-byte transmit and receive identifier stores
// - Trace byte taken from and put to overhead
// - Alarms force received trace data to ones
// - Line order MSB first, bit 7 first
// - Transmit store survives device and port reset
// - Transmit reorder picks bit 0 first
// - Transmit alignment: one on byte 0, else zero
// - Transmit inversion after reorder and alignment
// - Transmit idle sends all zeros
// - Receive inversion precedes all receive processing
// - Receive alignment hunts one, checks fifteen zeros
// - Without alignment store from any byte
// - Consecutive locations, aligned byte goes first
// - Five identical new identifiers update and flag
// - Idle on five zero, clear on five non-zero
// - Unstable on eight unknown, clear on five non-zero or on idle
// - Mismatch compares seven payload bits only
// - Programmable expected identifier, own enable
// - No alignment means no expected comparison
// - No mismatch before first receive update
// - Receive reorder puts first bit at 0
// - Stores reachable with line clock stopped
// - Receive side holds three sixteen-byte identifiers
module e3tt_trace_ctrl
   import e3tt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       ce,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rdata,
   input  wire logic       line_clk,
   input  wire logic       frame_strobe,
   input  wire logic [7:0] rx_oh_byte,
   input  wire logic       rx_los,
   input  wire logic       rx_lof,
   input  wire logic       rx_ais,
   input  wire logic       datapath_reset_n,
   output logic      [7:0] tx_oh_byte,
   output logic            trace_change,
   output logic            trace_idle,
   output logic            trace_unstable,
   output logic            trace_mismatch,
   output logic            trace_locked
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] bit_rev(input logic [7:0] b);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return r;
   endfunction

   // Payload mask in stored order: the alignment bit moves with reordering
   function automatic logic [7:0] stored_mask(input logic reorder);
      return reorder ? bit_rev(E3TT_PAYLOAD_MASK) : E3TT_PAYLOAD_MASK;
   endfunction

   function automatic logic id_match(input e3tt_id_t a, input e3tt_id_t b,
                                     input logic [7:0] m);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < E3TT_ID_BYTES; i++) begin
         if (((a[i] ^ b[i]) & m) != 8'h00) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   function automatic logic [3:0] sat_inc(input logic [3:0] c);
      return (c == 4'hf) ? c : c + 4'h1;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   e3tt_state_t s;
   e3tt_state_t next_s;

   logic        line_fall;
   logic        frame;
   logic        rx_alarm;
   logic [7:0]  rx_line;
   logic [7:0]  rx_store;
   logic [7:0]  rx_mask;
   logic [7:0]  tx_line;
   logic        accept;
   logic [3:0]  pos;
   logic        first;
   logic        b_same;
   logic        b_rx;
   logic        b_zero;
   logic        id_same;
   logic        id_rx;
   logic        id_zero;

   always_comb begin
      next_s   = s;
      line_fall = 1'b0;
      frame    = 1'b0;
      rx_alarm = 1'b0;
      rx_line  = '0;
      rx_store = '0;
      rx_mask  = '0;
      tx_line  = '0;
      accept   = 1'b0;
      pos      = '0;
      first    = 1'b0;
      b_same   = 1'b0;
      b_rx     = 1'b0;
      b_zero   = 1'b0;
      id_same  = 1'b0;
      id_rx    = 1'b0;
      id_zero  = 1'b0;

      // ****************************************************************
      // Line input sampling
      // ****************************************************************
      // Every line pin passes two flops so the checks below see settled levels
      next_s.sync1.lclk   = line_clk;
      next_s.sync1.strobe = frame_strobe;
      next_s.sync1.alarm  = {rx_los, rx_lof, rx_ais};
      next_s.sync1.datapath_reset_n_n = datapath_reset_n;
      next_s.sync1.data   = rx_oh_byte;
      next_s.sync2        = s.sync1;
      next_s.lclk_prev    = s.sync2.lclk;

      // Falling edge is mid-period, where the framer's byte and strobe are stable
      line_fall = s.lclk_prev & ~s.sync2.lclk;
      frame     = line_fall & s.sync2.strobe;

      // ****************************************************************
      // Register port
      // ****************************************************************
      // All stores live on clk, so software access needs no line clock
      next_s.rdata = '0;
      if (rd_en) begin
         if (addr == E3TT_ADDR_CTRL) begin
            next_s.rdata = s.ctrl;
         end else if (addr == E3TT_ADDR_STATUS) begin
            next_s.rdata[E3TT_STAT_CHANGE]   = s.change;
            next_s.rdata[E3TT_STAT_IDLE]     = s.idle;
            next_s.rdata[E3TT_STAT_UNSTABLE] = s.unstable;
            next_s.rdata[E3TT_STAT_MISMATCH] = s.mismatch;
            next_s.rdata[E3TT_STAT_LOCKED]   = (s.astate == E3TT_SYNC);
            next_s.rdata[E3TT_STAT_RXVALID]  = s.rx_valid;
         end else begin
            unique case (addr[7:4])
               E3TT_PAGE_TX: begin
                  next_s.rdata = s.tx_id[addr[3:0]];
               end
               E3TT_PAGE_EXP: begin
                  next_s.rdata = s.exp_id[addr[3:0]];
               end
               E3TT_PAGE_CUR: begin
                  next_s.rdata = s.cur_id[addr[3:0]];
               end
               E3TT_PAGE_RX: begin
                  next_s.rdata = s.rx_id[addr[3:0]];
               end
               default: begin
                  next_s.rdata = '0;
               end
            endcase
         end
      end
      if (wr_en) begin
         if (addr == E3TT_ADDR_CTRL) begin
            next_s.ctrl = wdata;
         end else if (addr == E3TT_ADDR_STATUS) begin
            // Write one clears; a change set in this cycle still wins below
            if (wdata[E3TT_STAT_CHANGE]) begin
               next_s.change = 1'b0;
            end
         end else if (addr[7:4] == E3TT_PAGE_TX) begin
            next_s.tx_id[addr[3:0]] = wdata;
         end else if (addr[7:4] == E3TT_PAGE_EXP) begin
            next_s.exp_id[addr[3:0]] = wdata;
         end
      end

      // ****************************************************************
      // Transmit trace processing
      // ****************************************************************
      tx_line = s.ctrl[E3TT_CTRL_TX_REORDER] ? bit_rev(s.tx_id[s.tx_pos])
                                             : s.tx_id[s.tx_pos];
      if (s.ctrl[E3TT_CTRL_TX_ALIGN]) begin
         tx_line[7] = (s.tx_pos == 4'h0);
      end
      if (s.ctrl[E3TT_CTRL_TX_INVERT]) begin
         tx_line = ~tx_line;
      end
      if (s.ctrl[E3TT_CTRL_TX_IDLE]) begin
         tx_line = '0;
      end
      if (frame) begin
         next_s.tx_byte = tx_line;
         next_s.tx_pos  = s.tx_pos + 4'h1;
      end

      // ****************************************************************
      // Receive trace processing
      // ****************************************************************
      rx_alarm = |s.sync2.alarm;
      rx_line  = s.sync2.data;
      if (s.ctrl[E3TT_CTRL_RX_INVERT]) begin
         rx_line = ~rx_line;
      end
      if (rx_alarm) begin
         rx_line = E3TT_ALL_ONES;
      end
      rx_store = s.ctrl[E3TT_CTRL_RX_REORDER] ? bit_rev(rx_line)
                                              : rx_line;
      rx_mask  = stored_mask(s.ctrl[E3TT_CTRL_RX_REORDER]);

      if (frame) begin
         if (!s.ctrl[E3TT_CTRL_RX_ALIGN]) begin
            accept = 1'b1;
            pos    = s.wr_pos;
         end else if (rx_line[7] && (s.astate == E3TT_HUNT || s.wr_pos != 4'h0)) begin
            // A start bit restarts the identifier at the first location
            accept        = 1'b1;
            pos           = 4'h0;
            next_s.astate = E3TT_SYNC;
         end else if (s.astate == E3TT_SYNC && rx_line[7] == (s.wr_pos == 4'h0)) begin
            accept = 1'b1;
            pos    = s.wr_pos;
         end else begin
            next_s.astate = E3TT_HUNT;
            next_s.wr_pos = 4'h0;
         end
      end

      if (accept) begin
         first   = (pos == 4'h0);
         // Compare byte against what it overwrites: the last current identifier
         b_same  = (rx_store == s.cur_id[pos]);
         b_rx    = (rx_store == s.rx_id[pos]);
         b_zero  = ((rx_store & rx_mask) == 8'h00);
         id_same = (first | s.trk.acc_same) & b_same;
         id_rx   = (first | s.trk.acc_rx) & b_rx & s.rx_valid;
         id_zero = (first | s.trk.acc_zero) & b_zero;
         next_s.trk.acc_same = id_same;
         next_s.trk.acc_rx   = id_rx;
         next_s.trk.acc_zero = id_zero;
         next_s.cur_id[pos]  = rx_store;
         next_s.wr_pos       = pos + 4'h1;

         if (pos == E3TT_LAST_POS) begin
            next_s.trk.same_cnt = (id_same && !id_zero) ? sat_inc(s.trk.same_cnt)
                                                        : (id_zero ? 4'h0 : 4'h1);
            next_s.trk.zero_cnt = id_zero ? sat_inc(s.trk.zero_cnt) : 4'h0;
            next_s.trk.nz_cnt   = id_zero ? 4'h0 : sat_inc(s.trk.nz_cnt);
            next_s.trk.unst_cnt = (!id_same && !id_rx) ? sat_inc(s.trk.unst_cnt)
                                                       : 4'h0;

            if (next_s.trk.same_cnt >= E3TT_CHANGE_REPEAT && !id_rx) begin
               next_s.rx_id    = next_s.cur_id;
               next_s.rx_valid = 1'b1;
               next_s.change   = 1'b1;
            end
            if (next_s.trk.nz_cnt >= E3TT_CLEAR_REPEAT) begin
               next_s.idle     = 1'b0;
               next_s.unstable = 1'b0;
            end
            if (next_s.trk.zero_cnt == E3TT_IDLE_REPEAT) begin
               next_s.idle     = 1'b1;
               next_s.unstable = 1'b0;
            end
            if (next_s.trk.unst_cnt == E3TT_UNSTABLE_REPEAT) begin
               next_s.unstable = 1'b1;
               next_s.idle     = 1'b0;
            end
         end
      end

      // ****************************************************************
      // Expected identifier comparison
      // ****************************************************************
      // Evaluated every cycle so an expected-value rewrite shows at once
      if (s.ctrl[E3TT_CTRL_CMP_EN] && s.ctrl[E3TT_CTRL_RX_ALIGN]
          && s.rx_valid) begin
         next_s.mismatch = !id_match(s.rx_id, s.exp_id, rx_mask);
      end else begin
         next_s.mismatch = 1'b0;
      end

      // ****************************************************************
      // Port reset
      // ****************************************************************
      // Clears receive and transmit sequencing, keeps all software stores
      if (!s.sync2.datapath_reset_n_n) begin
         next_s.tx_pos   = '0;
         next_s.tx_byte  = '0;
         next_s.rx_valid = 1'b0;
         next_s.astate   = E3TT_HUNT;
         next_s.wr_pos   = '0;
         next_s.trk      = '0;
         next_s.change   = 1'b0;
         next_s.idle     = 1'b0;
         next_s.unstable = 1'b0;
         next_s.mismatch = 1'b0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // The transmit store takes no reset value so its contents survive resets
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s.sync1     <= '0;
         s.sync2     <= '0;
         s.lclk_prev <= 1'b0;
         s.ctrl      <= E3TT_CTRL_RESET;
         s.rdata     <= '0;
         s.tx_pos    <= '0;
         s.tx_byte   <= '0;
         s.cur_id    <= '0;
         s.rx_id     <= '0;
         s.exp_id    <= '0;
         s.rx_valid  <= 1'b0;
         s.astate    <= E3TT_HUNT;
         s.wr_pos    <= '0;
         s.trk       <= '0;
         s.change    <= 1'b0;
         s.idle      <= 1'b0;
         s.unstable  <= 1'b0;
         s.mismatch  <= 1'b0;
      end else if (ce) begin
         s.sync1     <= next_s.sync1;
         s.sync2     <= next_s.sync2;
         s.lclk_prev <= next_s.lclk_prev;
         s.ctrl      <= next_s.ctrl;
         s.rdata     <= next_s.rdata;
         s.tx_id     <= next_s.tx_id;
         s.tx_pos    <= next_s.tx_pos;
         s.tx_byte   <= next_s.tx_byte;
         s.cur_id    <= next_s.cur_id;
         s.rx_id     <= next_s.rx_id;
         s.exp_id    <= next_s.exp_id;
         s.rx_valid  <= next_s.rx_valid;
         s.astate    <= next_s.astate;
         s.wr_pos    <= next_s.wr_pos;
         s.trk       <= next_s.trk;
         s.change    <= next_s.change;
         s.idle      <= next_s.idle;
         s.unstable  <= next_s.unstable;
         s.mismatch  <= next_s.mismatch;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign rdata          = s.rdata;
   assign tx_oh_byte     = s.tx_byte;
   assign trace_change   = s.change;
   assign trace_idle     = s.idle;
   assign trace_unstable = s.unstable;
   assign trace_mismatch = s.mismatch;
   assign trace_locked   = (s.astate == E3TT_SYNC);

endmodule

// >>> e3tt_trace_ctrl_properties.sv
// Port-level assertions for the trail trace controller
`timescale 1ns/100ps
module e3tt_checker
   import e3tt_pkg::*;
(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rdata,
   input wire logic       frame_strobe,
   input wire logic       datapath_reset_n,
   input wire logic [7:0] tx_oh_byte,
   input wire logic       trace_change,
   input wire logic       trace_idle,
   input wire logic       trace_unstable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ************************************************************
   // Sequences
   // ************************************************************
   sequence s_wr_ctrl;
      wr_en && addr == E3TT_ADDR_CTRL;
   endsequence
   sequence s_rd_ctrl;
      rd_en && !wr_en && addr == E3TT_ADDR_CTRL;
   endsequence

   // ************************************************************
   // Assertions
   // ************************************************************
   rdata_quiet_a: assert property (!rd_en |=> rdata == 8'h00)
      else $error("read data outside read slot");
   unmapped_read_a: assert property (rd_en && addr == 8'h05 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   status_spare_a: assert property (rd_en && addr == E3TT_ADDR_STATUS |=> rdata[7:6] == 2'b00)
      else $error("status spare bits set");
   ctrl_readback_a: assert property (s_wr_ctrl ##1 !wr_en ##1 s_rd_ctrl |=>
      rdata == $past(wdata, 3))
      else $error("control readback wrong");
   idle_unstable_excl_a: assert property (!(trace_idle && trace_unstable))
      else $error("idle and unstable together");
   // Port reset also clears the byte and the flags, two cycles after its pin falls
   tx_on_frame_a: assert property ($changed(tx_oh_byte) |->
      $past(frame_strobe, 4) || !$past(datapath_reset_n, 2))
      else $error("transmit byte moved without frame");
   flag_on_frame_a: assert property ($rose(trace_idle) || $rose(trace_change) |->
      $past(frame_strobe, 4))
      else $error("flag rose without frame");
   change_sticky_a: assert property ($fell(trace_change) |->
      ($past(wr_en) && $past(addr) == E3TT_ADDR_STATUS && $past(wdata[0]))
      || !$past(datapath_reset_n, 2))
      else $error("change flag lost without clear");
endmodule

bind e3tt_trace_ctrl e3tt_checker chk_u (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .frame_strobe(frame_strobe),
   .datapath_reset_n(datapath_reset_n),
   .tx_oh_byte(tx_oh_byte), .trace_change(trace_change), .trace_idle(trace_idle),
   .trace_unstable(trace_unstable));

// >>> e3tt_framer_model.sv
// Behavioural framer that feeds and takes the trace overhead byte
`timescale 1ns/100ps
module e3tt_framer_model
   import e3tt_pkg::*;
(
   input  wire e3tt_id_t   rx_id,
   input  wire logic [7:0] tx_byte,
   output logic            line_clk,
   output logic            frame_strobe,
   output logic [7:0]      rx_byte,
   output logic [7:0]      tx_taken
);
   logic [3:0] pos;
   logic       gap;

   // Odd start offset keeps line clock edges 0.5 ns after system clock edges, never on them
   initial begin
      line_clk = 1'b0;
      frame_strobe = 1'b0;
      rx_byte = 8'h00;
      tx_taken = 8'h00;
      pos = 4'h0;
      gap = 1'b0;
      #13;
      forever #100 line_clk = ~line_clk;
   end

   // One byte every other line period; the data line toggles between frames
   always @(posedge line_clk) begin
      gap <= ~gap;
      if (!gap) begin
         frame_strobe <= 1'b1;
         rx_byte      <= rx_id[pos];
         pos          <= pos + 4'h1;
         tx_taken     <= tx_byte;
      end else begin
         frame_strobe <= 1'b0;
         rx_byte      <= ~rx_byte;
      end
   end
endmodule

// >>> testbench.sv
// Self-checking bench for the trail trace controller
`timescale 1ns/100ps
module testbench
   import e3tt_pkg::*;
;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic        rx_los = 1'b0;
   logic        dp_reset_n = 1'b1;
   logic        seen_unst = 1'b0;
   logic [7:0]  rdata, tx_oh_byte, rx_oh_byte, tx_taken, n0, n1;
   logic        line_clk, frame_strobe, t_chg, t_idle, t_unst, t_mis, t_lock;
   e3tt_id_t    fid, a_id;
   int          fail_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   // Control value, byte at alignment slot, byte elsewhere
   logic [23:0] rows [7] = '{24'h003535, 24'h01acac, 24'h02b535, 24'h04caca,
                              24'h064aca, 24'h080000, 24'h03ac2c};

   always #12.5 clk = ~clk;

   e3tt_trace_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .line_clk(line_clk),
      .frame_strobe(frame_strobe), .rx_oh_byte(rx_oh_byte), .rx_los(rx_los), .rx_lof(1'b0),
      .rx_ais(1'b0), .datapath_reset_n(dp_reset_n), .tx_oh_byte(tx_oh_byte), .trace_change(t_chg),
      .trace_idle(t_idle), .trace_unstable(t_unst), .trace_mismatch(t_mis),
      .trace_locked(t_lock));
   e3tt_framer_model fm_u (.rx_id(fid), .tx_byte(tx_oh_byte), .line_clk(line_clk),
      .frame_strobe(frame_strobe), .rx_byte(rx_oh_byte), .tx_taken(tx_taken));

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 check(rdata, exp, what);
      @(posedge clk);
   endtask
   task automatic frames(input int n);
      repeat (n) @(posedge frame_strobe);
      @(posedge clk);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         $display("[FAIL] %0t run did not finish", $time);
         report_and_stop();
      end
   end

   // Unstable stands for one identifier only, so it is caught as it passes
   always @(posedge clk) begin
      if (t_unst === 1'b1) begin
         seen_unst <= 1'b1;
      end
   end

   initial begin
      for (int k = 0; k < 16; k++) a_id[k] = 8'h41 + 8'(k);
      a_id[0] = a_id[0] | 8'h80;
      fid = ~a_id;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 16; k++) wr(8'h10 + 8'(k), 8'h35);
      foreach (rows[i]) begin
         wr(E3TT_ADDR_CTRL, rows[i][23:16]);
         rd(E3TT_ADDR_CTRL, rows[i][23:16], "ctrl readback");
         frames(3);
         n0 = 8'h00;
         n1 = 8'h00;
         repeat (16) begin
            @(posedge frame_strobe);
            #1 n0 = n0 + 8'(tx_taken === rows[i][15:8]);
            n1 = n1 + 8'(tx_taken === rows[i][7:0]);
         end
         @(posedge clk);
         // Equal slot bytes mean every byte matches both counts
         check(n0, (rows[i][15:8] == rows[i][7:0]) ? 8'h10 : 8'h01, "tx slot");
         check(n1, (rows[i][15:8] == rows[i][7:0]) ? 8'h10 : 8'h0f, "tx rest");
         $display("tx row %0d done", i);
      end
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(8'h1f, 8'h35, "tx store kept");
      rd(E3TT_ADDR_CTRL, E3TT_CTRL_RESET, "ctrl reset");
      rd(8'h05, 8'h00, "unmapped");
      $display("reset test done");
      for (int k = 0; k < 16; k++) wr(8'h20 + 8'(k), (a_id[k] & 8'h7f) ^ 8'(k == 5));
      wr(E3TT_ADDR_CTRL, 8'hb0);
      frames(32);
      check({7'h00, t_mis}, 8'h00, "early mismatch");
      frames(160);
      rd(E3TT_ADDR_STATUS, 8'h39, "status update");
      check({7'h00, t_lock}, 8'h01, "locked");
      for (int k = 0; k < 16; k++) rd(8'h40 + 8'(k), a_id[k], "rx id");
      wr(8'h25, a_id[5] & 8'h7f);
      rd(E3TT_ADDR_STATUS, 8'h31, "payload match");
      wr(8'h25, a_id[5] ^ 8'h01);
      wr(E3TT_ADDR_CTRL, 8'h30);
      rd(E3TT_ADDR_STATUS, 8'h31, "compare off");
      wr(E3TT_ADDR_CTRL, 8'h90);
      repeat (4) @(posedge clk);
      check({7'h00, t_mis}, 8'h00, "align off");
      wr(E3TT_ADDR_STATUS, 8'h01);
      check({7'h00, t_chg}, 8'h00, "change clear");
      $display("compare test done");
      fid = ~{8'h80, {15{8'h00}}};
      wr(E3TT_ADDR_CTRL, 8'h30);
      frames(160);
      check({7'h00, t_idle}, 8'h01, "idle set");
      rd(8'h41, a_id[1], "zero id not stored");
      $display("idle test done");
      rx_los <= 1'b1;
      wr(E3TT_ADDR_CTRL, 8'h00);
      frames(160);
      check({7'h00, t_idle}, 8'h00, "idle clear");
      check({7'h00, t_chg}, 8'h01, "alarm update");
      for (int k = 0; k < 16; k++) rd(8'h40 + 8'(k), E3TT_ALL_ONES, "alarm ones");
      $display("alarm test done");
      rx_los <= 1'b0;
      for (int j = 1; j < 12; j++) begin
         fid <= {16{8'(j)}};
         frames(16);
      end
      check({7'h00, seen_unst}, 8'h01, "unstable seen");
      rd(8'h40, E3TT_ALL_ONES, "unknown id not stored");
      $display("unstable test done");
      dp_reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      dp_reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(E3TT_ADDR_STATUS, 8'h00, "port reset status");
      check({7'h00, t_lock}, 8'h00, "port reset unlocked");
      rd(8'h10, 8'h35, "tx store kept on port reset");
      $display("port reset test done");
      report_and_stop();
   end
endmodule
